// ---- src/port_pin_override_mux.sv ----
// Port block: pin registers on APB, per-pin override muxes, pad controls.
// Assumes APB and all override sources run on sys_clk_i; pads are outside.
//
// What this block does
// - Pull-up follows the override value while its override select is high.
// - Without pull-up override, pull-up follows the pin pull-up register bit.
// - Driver enable follows the direction override value while its select is high.
// - Without direction override, driver enable follows the pin direction bit.
// - Driven pin takes the value override when its select is high.
// - Driven pin takes the output latch bit when no value override.
// - Toggle override high inverts the pin output latch bit.
// - Input enable follows its override value regardless of sleep state.
// - Without input override, input enable comes from chip sleep state.
// - Alternate functions get the unsynchronised Schmitt output; they synchronise it.
// - Analog line of each pin is tied straight to the pad.
// - Register strobes shared per port; clock and sleep shared; rest per pin.
// - Sleep clamp forces digital inputs low in deep sleep unless overridden.
// - Writing one to an input register bit toggles that output latch bit.
// - All pins go high impedance as soon as reset is active.
`timescale 1ns/1ps
module port_pin_override_mux (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [port_mux_pkg::APB_AW-1:0] paddr_i,
    input wire logic [port_mux_pkg::APB_DW-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [port_mux_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sleep controller clamp
    input wire logic sleep_i,
    // Alternate-function overrides, one bit per pin
    input wire logic [port_mux_pkg::NUM_PINS-1:0] pullup_override_sel_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] pullup_override_val_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] direction_override_sel_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] direction_override_val_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] value_override_sel_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] value_override_val_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] latch_toggle_override_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] input_enable_override_sel_i,
    input wire logic [port_mux_pkg::NUM_PINS-1:0] input_enable_override_val_i,
    // Taps to alternate functions
    output logic [port_mux_pkg::NUM_PINS-1:0] alternate_function_input_tap_o,
    output logic [port_mux_pkg::NUM_PINS-1:0] analog_pad_link_o,
    // Pads
    input wire logic [port_mux_pkg::NUM_PINS-1:0] pad_i,
    output logic [port_mux_pkg::NUM_PINS-1:0] pad_o,
    output logic [port_mux_pkg::NUM_PINS-1:0] pad_oe_n_o,
    output logic [port_mux_pkg::NUM_PINS-1:0] pullup_en_o
);

    localparam int N = port_mux_pkg::NUM_PINS;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [N-1:0] pin_pullup_bit_r;
    logic [N-1:0] pin_direction_bit_r;
    logic [N-1:0] pin_output_latch_bit_r;
    logic [N-1:0] pin_output_latch_bit_nxt;
    logic [N-1:0] pin_input_bit;
    logic [port_mux_pkg::APB_DW-1:0] prdata_r;
    logic [port_mux_pkg::APB_DW-1:0] rdata_nxt;

    // Per-pin results of the override muxes.
    logic [N-1:0] drive_en;
    logic [N-1:0] drive_val;
    logic [N-1:0] pullup_sel;
    logic [N-1:0] input_en;
    logic [N-1:0] tap;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic access;
    logic setup;
    logic hit_pullup;
    logic hit_direction;
    logic hit_latch;
    logic hit_input;
    logic addr_hit;
    logic lane0;
    logic pullup_reg_write_strobe;
    logic direction_reg_write_strobe;
    logic latch_reg_write_strobe;
    logic input_reg_write_strobe;
    logic [N-1:0] wdata;

    assign access = psel_i & penable_i;
    assign setup = psel_i & ~penable_i;
    assign hit_pullup = (paddr_i == port_mux_pkg::PULLUP_REG_OFS);
    assign hit_direction = (paddr_i == port_mux_pkg::DIRECTION_REG_OFS);
    assign hit_latch = (paddr_i == port_mux_pkg::LATCH_REG_OFS);
    assign hit_input = (paddr_i == port_mux_pkg::INPUT_REG_OFS);
    assign addr_hit = hit_pullup | hit_direction | hit_latch | hit_input;
    // Pin bits sit in byte lane 0, so only that strobe matters.
    assign lane0 = pstrb_i[0];
    assign wdata = pwdata_i[N-1:0];

    // One strobe per register, shared by every pin of the port.
    assign pullup_reg_write_strobe = access & pwrite_i & hit_pullup & lane0;
    assign direction_reg_write_strobe = access & pwrite_i & hit_direction & lane0;
    assign latch_reg_write_strobe = access & pwrite_i & hit_latch & lane0;
    assign input_reg_write_strobe = access & pwrite_i & hit_input & lane0;

    // Zero wait states; unmapped addresses answer with an error.
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~addr_hit;
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = port_mux_pkg::RDATA_ZERO;
        if (hit_pullup) begin
            rdata_nxt[N-1:0] = pin_pullup_bit_r;
        end else if (hit_direction) begin
            rdata_nxt[N-1:0] = pin_direction_bit_r;
        end else if (hit_latch) begin
            rdata_nxt[N-1:0] = pin_output_latch_bit_r;
        end else if (hit_input) begin
            rdata_nxt[N-1:0] = pin_input_bit;
        end else begin
            rdata_nxt = port_mux_pkg::RDATA_ZERO;
        end
    end

    // Captured in the setup cycle so the data stands through the access phase.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prdata_r <= port_mux_pkg::RDATA_ZERO;
        end else if (setup & ~pwrite_i) begin
            prdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pull-up and direction registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_pullup_bit_r <= port_mux_pkg::PIN_REG_RST;
        end else if (pullup_reg_write_strobe) begin
            pin_pullup_bit_r <= wdata;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_direction_bit_r <= port_mux_pkg::PIN_REG_RST;
        end else if (direction_reg_write_strobe) begin
            pin_direction_bit_r <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Output latch with toggle paths
    // ------------------------------------------------------------
    // A plain write lands first; both toggle sources then flip on top of it,
    // so a toggle arriving with a write is never lost.
    always_comb begin
        pin_output_latch_bit_nxt = pin_output_latch_bit_r;
        if (latch_reg_write_strobe) begin
            pin_output_latch_bit_nxt = wdata;
        end
        if (input_reg_write_strobe) begin
            pin_output_latch_bit_nxt = pin_output_latch_bit_nxt ^ wdata;
        end
        pin_output_latch_bit_nxt = pin_output_latch_bit_nxt ^ latch_toggle_override_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_output_latch_bit_r <= port_mux_pkg::PIN_REG_RST;
        end else begin
            pin_output_latch_bit_r <= pin_output_latch_bit_nxt;
        end
    end

    // ------------------------------------------------------------
    // Per-pin override muxes
    // ------------------------------------------------------------
    // Alternate-function modules own the select lines; unused pins hold them low.
    for (genvar g = 0; g < N; g++) begin : g_pin
        pin_ovr_if ovr ();

        assign ovr.pullup_override_sel = pullup_override_sel_i[g];
        assign ovr.pullup_override_val = pullup_override_val_i[g];
        assign ovr.direction_override_sel = direction_override_sel_i[g];
        assign ovr.direction_override_val = direction_override_val_i[g];
        assign ovr.value_override_sel = value_override_sel_i[g];
        assign ovr.value_override_val = value_override_val_i[g];
        assign ovr.input_enable_override_sel = input_enable_override_sel_i[g];
        assign ovr.input_enable_override_val = input_enable_override_val_i[g];

        pin_override_mux u_mux (
            .pin_direction_bit_i(pin_direction_bit_r[g]),
            .pin_output_latch_bit_i(pin_output_latch_bit_r[g]),
            .pin_pullup_bit_i(pin_pullup_bit_r[g]),
            .sleep_i(sleep_i),
            .pad_level_i(pad_i[g]),
            .ovr(ovr.mux),
            .drive_en_o(drive_en[g]),
            .drive_val_o(drive_val[g]),
            .pullup_en_o(pullup_sel[g]),
            .input_en_o(input_en[g]),
            .tap_o(tap[g])
        );
    end

    // ------------------------------------------------------------
    // Input register synchroniser
    // ------------------------------------------------------------
    level_sync #(
        .WIDTH(N)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .d_i(tap),
        .q_o(pin_input_bit)
    );

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    // Reset gates the driver and pull-up without waiting for a clock edge.
    assign pad_oe_n_o = ~(drive_en & {N{rstn_i}});
    assign pad_o = drive_val & {N{rstn_i}};
    assign pullup_en_o = pullup_sel & {N{rstn_i}};
    assign alternate_function_input_tap_o = tap;
    assign analog_pad_link_o = pad_i;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_input_write;
        psel_i && penable_i && pwrite_i && lane0 && hit_input;
    endsequence

    sequence s_latch_quiet;
        !latch_reg_write_strobe && !input_reg_write_strobe;
    endsequence

    // A read setup cycle; the data for it is captured at the edge that ends it.
    sequence s_read_setup;
        psel_i && !penable_i && !pwrite_i;
    endsequence

    a_pullup_override: assert property (
        (pullup_en_o & pullup_override_sel_i) == (pullup_override_val_i & pullup_override_sel_i))
        else $error("pull-up ignores its override value");

    a_pullup_register: assert property (
        (pullup_en_o & ~pullup_override_sel_i) == (pin_pullup_bit_r & ~pullup_override_sel_i))
        else $error("pull-up does not follow its register bit");

    a_direction_override: assert property (
        (~pad_oe_n_o & direction_override_sel_i) == (direction_override_val_i & direction_override_sel_i))
        else $error("driver enable ignores its override value");

    a_direction_register: assert property (
        direction_reg_write_strobe && direction_override_sel_i == '0
        |=> ~pad_oe_n_o == $past(wdata))
        else $error("driver enable does not follow a direction write");

    a_value_override: assert property (
        (pad_o & ~pad_oe_n_o & value_override_sel_i)
        == (value_override_val_i & ~pad_oe_n_o & value_override_sel_i))
        else $error("driven value ignores its override");

    a_value_latch: assert property (
        (pad_o & ~pad_oe_n_o & ~value_override_sel_i)
        == (pin_output_latch_bit_r & ~pad_oe_n_o & ~value_override_sel_i))
        else $error("driven value does not follow the latch");

    a_latch_toggle: assert property (
        s_latch_quiet |=> pin_output_latch_bit_r
        == ($past(pin_output_latch_bit_r) ^ $past(latch_toggle_override_i)))
        else $error("toggle override did not invert the latch");

    a_input_override: assert property (
        (alternate_function_input_tap_o & input_enable_override_sel_i & ~input_enable_override_val_i) == '0)
        else $error("disabled input leaks through its override");

    a_sleep_clamp: assert property (
        sleep_i |-> (alternate_function_input_tap_o & ~input_enable_override_sel_i) == '0)
        else $error("sleep clamp did not force the input low");

    a_awake_input: assert property (
        !sleep_i |-> (input_en | input_enable_override_sel_i) == '1)
        else $error("input disabled while awake without override");

    a_tap_to_register: assert property (
        pin_input_bit == $past(alternate_function_input_tap_o, 2))
        else $error("input register is not the tap two cycles late");

    a_pin_toggle_write: assert property (
        s_input_write ##0 !latch_reg_write_strobe && latch_toggle_override_i == '0
        |=> pin_output_latch_bit_r == ($past(pin_output_latch_bit_r) ^ $past(wdata)))
        else $error("input register write did not toggle the latch");

    a_reset_tristate: assert property (
        @(posedge sys_clk_i) disable iff (1'b0)
        !rstn_i |-> (&pad_oe_n_o) && pullup_en_o == '0)
        else $error("pad driven during reset");

    a_undriven_quiet: assert property (
        (pad_o & pad_oe_n_o) == '0)
        else $error("pad value present while undriven");

    a_apb_error: assert property (
        access && !addr_hit |-> pslverr_o && pready_o)
        else $error("unmapped access without error answer");

    // Read data must be the register value that stood in the setup cycle.
    a_read_latch: assert property (
        s_read_setup ##0 hit_latch |=> prdata_o[N-1:0] == $past(pin_output_latch_bit_r))
        else $error("latch read does not show the latch bits");

    a_read_input: assert property (
        s_read_setup ##0 hit_input |=> prdata_o[N-1:0] == $past(pin_input_bit))
        else $error("input read does not show the synchronised pins");

    // A refused write is either an unmapped address or a cleared lane 0 strobe.
    a_write_refused: assert property (
        access && pwrite_i && (!lane0 || !addr_hit)
        |=> $stable(pin_pullup_bit_r) && $stable(pin_direction_bit_r))
        else $error("refused write changed a pin register");

    a_analog_link: assert property (
        analog_pad_link_o == pad_i)
        else $error("analog line differs from the pad");

endmodule

// ---- src/port_mux_pkg.sv ----
// Shared constants for the port pin override multiplexer.
// Assumes a single 50 MHz I/O clock and a 32-bit APB register bus.
package port_mux_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int NUM_PINS = 4;
    localparam int APB_AW = 32;
    localparam int APB_DW = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] PULLUP_REG_OFS = 32'h0000_0000;
    localparam logic [APB_AW-1:0] DIRECTION_REG_OFS = 32'h0000_0004;
    localparam logic [APB_AW-1:0] LATCH_REG_OFS = 32'h0000_0008;
    localparam logic [APB_AW-1:0] INPUT_REG_OFS = 32'h0000_000C;

    // ------------------------------------------------------------
    // Reset values and read fill
    // ------------------------------------------------------------
    localparam logic [NUM_PINS-1:0] PIN_REG_RST = 4'h0;
    localparam logic [APB_DW-1:0] RDATA_ZERO = 32'h0000_0000;
    localparam int SYNC_STAGES = 2;

endpackage

// ---- src/pin_ovr_if.sv ----
// Override bundle for one pin, from the alternate-function logic to the mux.
// Assumes the alternate-function module drives every member each cycle.
`timescale 1ns/1ps
interface pin_ovr_if;
    logic pullup_override_sel;
    logic pullup_override_val;
    logic direction_override_sel;
    logic direction_override_val;
    logic value_override_sel;
    logic value_override_val;
    logic input_enable_override_sel;
    logic input_enable_override_val;

    modport source (
        output pullup_override_sel,
        output pullup_override_val,
        output direction_override_sel,
        output direction_override_val,
        output value_override_sel,
        output value_override_val,
        output input_enable_override_sel,
        output input_enable_override_val
    );

    modport mux (
        input pullup_override_sel,
        input pullup_override_val,
        input direction_override_sel,
        input direction_override_val,
        input value_override_sel,
        input value_override_val,
        input input_enable_override_sel,
        input input_enable_override_val
    );
endinterface

// ---- src/level_sync.sv ----
// Two-stage level synchroniser for a bus of independent bits.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] stage1_r;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            stage1_r <= '0;
            q_o <= '0;
        end else begin
            stage1_r <= d_i;
            q_o <= stage1_r;
        end
    end

endmodule

// ---- src/pin_override_mux.sv ----
// Combinational override mux for one port pin.
// Assumes register bits come from flops on the I/O clock.
`timescale 1ns/1ps
module pin_override_mux (
    // Register bits and chip state
    input wire logic pin_direction_bit_i,
    input wire logic pin_output_latch_bit_i,
    input wire logic pin_pullup_bit_i,
    input wire logic sleep_i,
    // Pad level after the Schmitt trigger
    input wire logic pad_level_i,
    // Alternate-function overrides
    pin_ovr_if.mux ovr,
    // Final pin controls
    output logic drive_en_o,
    output logic drive_val_o,
    output logic pullup_en_o,
    output logic input_en_o,
    output logic tap_o
);

    always_comb begin
        if (ovr.pullup_override_sel) begin
            pullup_en_o = ovr.pullup_override_val;
        end else begin
            pullup_en_o = pin_pullup_bit_i;
        end
        if (ovr.direction_override_sel) begin
            drive_en_o = ovr.direction_override_val;
        end else begin
            drive_en_o = pin_direction_bit_i;
        end
        // The value is gated with the driver so an undriven pad shows a quiet low.
        if (ovr.value_override_sel) begin
            drive_val_o = drive_en_o & ovr.value_override_val;
        end else begin
            drive_val_o = drive_en_o & pin_output_latch_bit_i;
        end
        if (ovr.input_enable_override_sel) begin
            input_en_o = ovr.input_enable_override_val;
        end else begin
            input_en_o = ~sleep_i;
        end
        // Clamped input reads low; the tap is taken ahead of any synchroniser.
        tap_o = pad_level_i & input_en_o;
    end

endmodule

// ---- dv/alt_func_model.sv ----
// Model of the alternate-function logic that feeds the override bundles of every pin.
// Assumes the bench supplies a request word and the mask of pins that have a function.
`timescale 1ns/1ps
module alt_func_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Requests from the bench
    input wire logic [31:0] req_i,
    input wire logic [3:0] used_i,
    input wire logic [3:0] tap_i,
    // Overrides, eight 4-bit fields, and the resynchronised tap
    output logic [31:0] ovr_o,
    output logic [3:0] tap_sync_o
);
    logic [3:0] sync_a_r;

    // Pins without a function keep every override field at zero.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ovr_o <= 32'h0000_0000;
        end else begin
            ovr_o <= req_i & {8{used_i}};
        end
    end

    // The tap arrives unsynchronised, so the function resamples it twice.
    always_ff @(posedge sys_clk_i) begin
        sync_a_r <= tap_i;
        tap_sync_o <= sync_a_r;
    end
endmodule

// ---- dv/test_port_pin_override_mux.sv ----
// Self-checking bench for the port pin override mux, with an APB master and an override source.
// Assumes zero-wait APB as handed over; expectations come from a copy of the pin registers.
`timescale 1ns/1ps
module test_port_pin_override_mux;
    logic sys_clk_i, rstn_i, psel_i, penable_i, pwrite_i, sleep_i, pready_o, pslverr_o, err;
    logic [31:0] paddr_i, pwdata_i, prdata_o, req, ovr, rd, wd;
    logic [3:0] pstrb_i, used, toggle, pad_i, pad_o, pad_oe_n_o, pullup_en_o, tap_o, analog_o, tap_sync, p;
    logic [3:0] pu_r, dir_r, latch_r;
    logic [31:0] regs [3];
    int n_errors, n_checks;

    // ------------------------------------------------------------
    // Design and override source
    // ------------------------------------------------------------
    port_pin_override_mux dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i), .pullup_override_sel_i(ovr[3:0]),
        .pullup_override_val_i(ovr[7:4]), .direction_override_sel_i(ovr[11:8]),
        .direction_override_val_i(ovr[15:12]), .value_override_sel_i(ovr[19:16]),
        .value_override_val_i(ovr[23:20]), .latch_toggle_override_i(toggle),
        .input_enable_override_sel_i(ovr[27:24]), .input_enable_override_val_i(ovr[31:28]),
        .alternate_function_input_tap_o(tap_o), .analog_pad_link_o(analog_o), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe_n_o(pad_oe_n_o), .pullup_en_o(pullup_en_o));
    alt_func_model afm (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req), .used_i(used), .tap_i(tap_o),
        .ovr_o(ovr), .tap_sync_o(tap_sync));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n == 16) begin
            n_errors++;
            stop_test();
        end
    endtask

    // The bench keeps its own copy of the pin registers; a write of ones to the input word flips latch bits.
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == port_mux_pkg::PULLUP_REG_OFS) pu_r = d[3:0];
        if (a == port_mux_pkg::DIRECTION_REG_OFS) dir_r = d[3:0];
        if (a == port_mux_pkg::LATCH_REG_OFS) latch_r = d[3:0];
        if (a == port_mux_pkg::INPUT_REG_OFS) latch_r = latch_r ^ d[3:0];
    endtask

    task automatic check_pins();
        logic [3:0] drv, pu, val, ie;
        drv = (ovr[11:8] & ovr[15:12]) | (~ovr[11:8] & dir_r);
        pu = (ovr[3:0] & ovr[7:4]) | (~ovr[3:0] & pu_r);
        val = drv & ((ovr[19:16] & ovr[23:20]) | (~ovr[19:16] & latch_r));
        ie = (ovr[27:24] & ovr[31:28]) | (~ovr[27:24] & {4{~sleep_i}});
        check(32'(pad_oe_n_o), {28'h000_0000, ~drv});
        check(32'(pullup_en_o), 32'(pu));
        check(32'(pad_o), 32'(val));
        check(32'(tap_o), 32'(pad_i & ie));
        check(32'(analog_o), 32'(pad_i));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, sleep_i} = 5'h00;
        {paddr_i, pwdata_i, req} = 96'h0;
        {used, toggle, pad_i, pu_r, dir_r, latch_r} = 24'h0;
        pstrb_i = 4'hF;
        n_errors = 0;
        n_checks = 0;
        regs = '{port_mux_pkg::PULLUP_REG_OFS, port_mux_pkg::DIRECTION_REG_OFS, port_mux_pkg::LATCH_REG_OFS};
        void'($urandom(18838));
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, regs[i], 32'h0);
            check(rd, port_mux_pkg::RDATA_ZERO);
        end
        // An unmapped write must be refused and leave every pin register alone.
        wr_reg(32'h0000_0010, 32'h0000_000F);
        check(32'(err), 32'h1);
        pstrb_i <= 4'h0;
        apb(1'b1, port_mux_pkg::DIRECTION_REG_OFS, 32'h0000_000F);
        pstrb_i <= 4'hF;
        @(negedge sys_clk_i);
        check_pins();
        for (int i = 0; i < 300; i++) begin
            @(posedge sys_clk_i);
            req <= $urandom();
            used <= 4'($urandom());
            sleep_i <= 1'($urandom());
            pad_i <= 4'($urandom());
            wd = $urandom();
            wr_reg(regs[$urandom_range(0, 2)], wd);
            @(negedge sys_clk_i);
            check_pins();
        end
        used <= 4'h0;
        wr_reg(port_mux_pkg::LATCH_REG_OFS, 32'h0000_0005);
        wr_reg(port_mux_pkg::INPUT_REG_OFS, 32'h0000_0003);
        apb(1'b0, port_mux_pkg::LATCH_REG_OFS, 32'h0);
        check(rd, 32'(latch_r));
        toggle <= 4'h9;
        @(posedge sys_clk_i);
        toggle <= 4'h0;
        latch_r = latch_r ^ 4'h9;
        apb(1'b0, port_mux_pkg::LATCH_REG_OFS, 32'h0);
        check(rd, 32'(latch_r));
        // Awake, clamped, then clamped but overridden to enabled.
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk_i);
            p = 4'($urandom()) | 4'h1;
            pad_i <= p;
            sleep_i <= (k != 0);
            used <= (k == 2) ? 4'hF : 4'h0;
            req <= 32'hFF00_0000;
            repeat (4) @(posedge sys_clk_i);
            apb(1'b0, port_mux_pkg::INPUT_REG_OFS, 32'h0);
            check(rd, (k == 1) ? 32'h0 : 32'(p));
            check(32'(tap_sync), (k == 1) ? 32'h0 : 32'(p));
        end
        wr_reg(port_mux_pkg::DIRECTION_REG_OFS, 32'h0000_000F);
        wr_reg(port_mux_pkg::PULLUP_REG_OFS, 32'h0000_000F);
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        @(negedge sys_clk_i);
        check(32'(pad_oe_n_o), 32'hF);
        check(32'(pad_o), 32'h0);
        check(32'(pullup_en_o), 32'h0);
        stop_test();
    end
endmodule
